// *** pkg/baro_cmd_pkg.sv ***
// Command codes, field layout, timing and carrier types of the sensor serial command port
package baro_cmd_pkg;

  // ----------------------------------------------------------------
  // Command byte layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RESET_CODE = 8'h1e;
  localparam logic [7:0] CMD_RESULT_CODE = 8'h00;
  localparam int MEMORY_READ_BIT = 7;
  localparam int CONVERSION_BIT = 6;
  localparam int FIXED_BIT = 5;
  localparam int TYPE_BIT = 4;
  localparam int FIELD_MSB = 3;
  localparam int FIELD_LSB = 1;
  localparam int STOP_BIT = 0;
  localparam logic [2:0] RATIO_MAX = 3'h4;

  // ----------------------------------------------------------------
  // Sizes and link constants
  // ----------------------------------------------------------------
  localparam int RESULT_W = 24;
  localparam int WORD_W = 16;
  localparam int MEM_WORDS = 8;
  localparam int MEM_W = 128;
  localparam int TAG_W = 4;
  localparam logic [5:0] I2C_ADDR_HI = 6'h3b;
  localparam logic [RESULT_W-1:0] CORRUPT_MASK = 24'h5a5a5a;
  localparam logic [MEM_W-1:0] FACTORY_IMAGE_DEF = 128'h0123_4567_89ab_cdef_1357_9bdf_2468_ace0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int CONV_BASE_NS = 600;
  localparam int CONV_BASE_CYC = (CONV_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_RESET = 3'b001,
    CMD_CONVERT = 3'b010,
    CMD_READ_RESULT = 3'b011,
    CMD_READ_MEM = 3'b100
  } cmd_kind_t;

  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_ADDR = 3'b001,
    L_ACK_A = 3'b010,
    L_WCMD = 3'b011,
    L_ACK_C = 3'b100,
    L_RDATA = 3'b101,
    L_RACK = 3'b110
  } link_state_t;

  typedef struct packed {
    logic [RESULT_W-1:0] pressure;
    logic [RESULT_W-1:0] temperature;
  } raw_sample_t;

  typedef struct packed {
    logic start;
    logic is_temperature;
    logic [2:0] ratio;
  } conv_req_t;

  typedef struct packed {
    logic busy;
    logic [TAG_W-1:0] tag;
    logic [RESULT_W-1:0] result;
    logic [MEM_W-1:0] mem;
  } core_view_t;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Classify a received command byte
  function automatic cmd_kind_t decode_cmd(input logic [7:0] c);
    cmd_kind_t k;
    k = CMD_NONE;
    if (c == CMD_RESET_CODE) begin
      k = CMD_RESET;
    end else if (c == CMD_RESULT_CODE) begin
      k = CMD_READ_RESULT;
    end else if (c[MEMORY_READ_BIT] && !c[CONVERSION_BIT] && c[FIXED_BIT] && !c[TYPE_BIT] && !c[STOP_BIT]) begin
      k = CMD_READ_MEM;
    end else if (!c[MEMORY_READ_BIT] && c[CONVERSION_BIT] && !c[FIXED_BIT] && !c[STOP_BIT]
                 && c[FIELD_MSB:FIELD_LSB] <= RATIO_MAX) begin
      k = CMD_CONVERT;
    end
    return k;
  endfunction

  // Check code x^4+x+1 over the whole memory image, msb first
  function automatic logic [3:0] crc4(input logic [MEM_W-1:0] m);
    logic [3:0] r;
    logic fb;
    r = 4'h0;
    for (int i = MEM_W - 1; i >= 0; i--) begin
      fb = r[3] ^ m[i];
      r = {r[2:0], 1'b0} ^ (fb ? 4'h3 : 4'h0);
    end
    return r;
  endfunction

endpackage

// *** verilog/level_sync.sv ***
// Two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps
module level_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge i_clk) begin
    meta_reg <= i_d;
    o_q <= meta_reg;
  end

endmodule

// *** verilog/cal_memory.sv ***
// Calibration memory: eight 16-bit words loaded from the factory image, check code inserted
`timescale 1ns/1ps
module cal_memory
  import baro_cmd_pkg::*;
#(
  parameter logic [MEM_W-1:0] IMAGE = FACTORY_IMAGE_DEF
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_load,
  output logic [MEM_W-1:0] o_words
);

  logic [WORD_W-1:0] mem_reg [MEM_WORDS];
  logic [MEM_W-1:0] image_clean;
  logic [MEM_W-1:0] image_full;

  // Word 7 low nibble carries the check code over the rest
  assign image_clean = {IMAGE[MEM_W-1:4], 4'h0};
  assign image_full = {IMAGE[MEM_W-1:4], crc4(image_clean)};

  // Load on reset and on the reset command
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || i_load) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem_reg[i] <= image_full[(MEM_WORDS-1-i)*WORD_W +: WORD_W];
      end
    end
  end

  // Word 0 sits in the top bits
  always_comb begin
    o_words = '0;
    for (int i = 0; i < MEM_WORDS; i++) begin
      o_words[(MEM_WORDS-1-i)*WORD_W +: WORD_W] = mem_reg[i];
    end
  end

endmodule

// *** verilog/baro_serial_port.sv ***
// Serial command port of a barometric sensor: four-wire and two-wire links, command core
//
// What this block does
// R1: Each received byte is one whole command.
// R2: Result read returns 24 bits; memory read returns 16 bits.
// R3: Memory read codes 0xa0..0xae carry word address in bits 3..1.
// R4: Reset command 0x1e reloads calibration memory and clears state.
// R5: Codes 0x40..0x48 start pressure conversion, ratio field 0..4.
// R6: Codes 0x50..0x58 start temperature conversion, same ratio field.
// R7: Result read after finished conversion shifts result out msb first.
// R8: Result read without conversion, or repeated, returns zero.
// R9: Result read during conversion returns zero, conversion runs on, result corrupted.
// R10: Host must not start a conversion while one runs.
// R11: Host may raise chip select during conversion in four-wire mode.
// R12: Eight 16-bit memory words, each shifted out msb first after command.
// R13: Word 0 factory data, words 1..6 coefficients, word 7 serial and check.
// R14: Host reads calibration memory once after every reset.
// R15: Two-wire messages open with start and close with stop.
// R16: Two-wire address is 111011C, C the inverse of select pin.
// R17: Two-wire reset command is accepted at any moment.
// R18: Host recovers a stuck data line with extra clocks then reset.
// R19: Two-wire memory read: write with command, then read transaction.
// R20: Two-wire conversion keeps device busy until done, result afterwards.
// R21: Two-wire result read clocks 24 bits after address acknowledge.
// R22: Two-wire read pauses every 8 bits for host acknowledge.
// R23: Calibration memory carries a 4-bit check code.
// R24: Four-wire link works in clock modes 0 and 3.
// R25: Protocol select low picks four-wire, high picks two-wire.
// R26: Unknown command bytes are ignored.
`timescale 1ns/1ps
module baro_serial_port
  import baro_cmd_pkg::*;
#(
  parameter int unsigned CONV_BASE_CYCLES = CONV_BASE_CYC,
  parameter logic [MEM_W-1:0] FACTORY_IMAGE = FACTORY_IMAGE_DEF
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_sclk,
  input wire logic i_serial_in_pin,
  input wire logic i_protocol_select_pin,
  input wire logic i_select_bar_pin,
  input wire raw_sample_t i_raw,
  output logic o_serial_out_pin,
  output logic o_serial_data_out,
  output logic o_serial_data_oe,
  output conv_req_t o_conv,
  output logic o_busy
);

  localparam int CNT_W = $clog2(CONV_BASE_CYCLES * 16 + 1);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] core_s;
  logic cmd_tgl_d_reg;
  logic cmd_evt;
  cmd_kind_t core_kind;
  logic corrupt_reg;
  logic is_temp_reg;
  logic [2:0] ratio_reg;
  logic [CNT_W-1:0] conv_cnt_reg;
  logic conv_done;
  logic corrupt_hit;
  logic [TAG_W-1:0] tag_reg;
  logic [RESULT_W-1:0] result_reg;
  logic [MEM_W-1:0] mem_words;
  logic mem_load;
  core_view_t view_live;
  core_view_t view_reg;
  logic view_req_reg;

  logic [3:0] lk_s;
  logic lk_rst;
  logic i2c_mode;
  logic addr_c;
  core_view_t lview_reg;
  logic view_ack_reg;
  logic frame_clr;
  logic start_tgl_reg;
  logic start_seen_reg;
  logic start_pend;
  link_state_t lst_reg;
  logic [3:0] bcnt_reg;
  logic [7:0] rx_reg;
  logic [RESULT_W-1:0] tx_reg;
  logic rw_reg;
  logic [7:0] byte_in;
  logic cmd_done;
  cmd_kind_t link_kind;
  logic fresh;
  logic [RESULT_W-1:0] resp_now;
  logic [RESULT_W-1:0] resp_reg;
  logic resp_is_mem_reg;
  logic rd_load;
  logic [7:0] cmd_byte_reg;
  logic cmd_tgl_reg;
  logic [TAG_W-1:0] served_tag_reg;

  // ----------------------------------------------------------------
  // Core domain: command arrival from the link
  // ----------------------------------------------------------------
  level_sync #(.W(2)) u_core_sync (
    .i_clk(i_ref_clk),
    .i_d({cmd_tgl_reg, view_ack_reg}),
    .o_q(core_s)
  );

  // Command byte is stable while its toggle crosses
  assign cmd_evt = core_s[1] ^ cmd_tgl_d_reg;
  assign core_kind = cmd_evt ? decode_cmd(cmd_byte_reg) : CMD_NONE; // [R1] [R26]

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      cmd_tgl_d_reg <= 1'b0;
    end else begin
      cmd_tgl_d_reg <= core_s[1];
    end
  end

  // ----------------------------------------------------------------
  // Core domain: conversion sequencing
  // ----------------------------------------------------------------
  assign conv_done = o_busy && conv_cnt_reg == CNT_W'(1);
  assign corrupt_hit = corrupt_reg || (core_kind == CMD_READ_RESULT); // [R9]

  // Busy timer, kind and ratio of the running conversion
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || core_kind == CMD_RESET) begin // [R4] [R17]
      o_busy <= 1'b0;
      corrupt_reg <= 1'b0;
      conv_cnt_reg <= '0;
      is_temp_reg <= 1'b0;
      ratio_reg <= 3'h0;
    end else if (core_kind == CMD_CONVERT) begin // [R5] [R6] [R20]
      o_busy <= 1'b1;
      corrupt_reg <= o_busy; // Restart during a conversion spoils it [R10]
      conv_cnt_reg <= CNT_W'(CONV_BASE_CYCLES) << cmd_byte_reg[FIELD_MSB:FIELD_LSB];
      is_temp_reg <= cmd_byte_reg[TYPE_BIT];
      ratio_reg <= cmd_byte_reg[FIELD_MSB:FIELD_LSB];
    end else begin
      if (core_kind == CMD_READ_RESULT && o_busy) begin
        corrupt_reg <= 1'b1; // Conversion keeps running [R9]
      end
      if (o_busy) begin
        conv_cnt_reg <= conv_cnt_reg - CNT_W'(1);
        if (conv_cnt_reg == CNT_W'(1)) begin
          o_busy <= 1'b0;
        end
      end
    end
  end

  // Start request to the converter
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_conv <= '0;
    end else begin
      o_conv.start <= core_kind == CMD_CONVERT;
      o_conv.is_temperature <= core_kind == CMD_CONVERT ? cmd_byte_reg[TYPE_BIT] : is_temp_reg;
      o_conv.ratio <= core_kind == CMD_CONVERT ? cmd_byte_reg[FIELD_MSB:FIELD_LSB] : ratio_reg;
    end
  end

  // Result capture and completion tag
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || core_kind == CMD_RESET) begin
      result_reg <= '0;
      tag_reg <= '0;
    end else if (conv_done) begin
      result_reg <= (is_temp_reg ? i_raw.temperature : i_raw.pressure)
                    ^ (corrupt_hit ? CORRUPT_MASK : '0); // [R9]
      tag_reg <= tag_reg + TAG_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Core domain: calibration memory
  // ----------------------------------------------------------------
  assign mem_load = core_kind == CMD_RESET; // [R4]

  cal_memory #(.IMAGE(FACTORY_IMAGE)) u_cal_memory ( // [R13] [R23]
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_load(mem_load),
    .o_words(mem_words)
  );

  // ----------------------------------------------------------------
  // Core domain: state view handed to the link by handshake
  // ----------------------------------------------------------------
  assign view_live = '{busy: o_busy, tag: tag_reg, result: result_reg, mem: mem_words};

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      view_reg <= '0;
      view_req_reg <= 1'b0;
    end else if (view_req_reg == core_s[0] && view_reg != view_live) begin
      view_reg <= view_live;
      view_req_reg <= ~view_req_reg;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: synchronised pins and view capture
  // ----------------------------------------------------------------
  level_sync #(.W(4)) u_link_sync (
    .i_clk(i_sclk),
    .i_d({i_srst, i_protocol_select_pin, i_select_bar_pin, view_req_reg}),
    .o_q(lk_s)
  );

  assign lk_rst = lk_s[3];
  assign i2c_mode = lk_s[2]; // [R25]
  assign addr_c = ~lk_s[1]; // [R16]

  always_ff @(posedge i_sclk) begin
    if (lk_rst) begin
      lview_reg <= '0;
      view_ack_reg <= 1'b0;
    end else if (lk_s[0] != view_ack_reg) begin
      lview_reg <= view_reg;
      view_ack_reg <= lk_s[0];
    end
  end

  // Start condition: data falls while clock is high
  always_ff @(negedge i_serial_in_pin or posedge lk_rst) begin
    if (lk_rst) begin
      start_tgl_reg <= 1'b0;
    end else if (i_sclk) begin
      start_tgl_reg <= ~start_tgl_reg; // [R15]
    end
  end

  // ----------------------------------------------------------------
  // Link domain: command decode and response word
  // ----------------------------------------------------------------
  assign start_pend = i2c_mode && (start_tgl_reg != start_seen_reg);
  assign byte_in = {rx_reg[6:0], i_serial_in_pin};
  assign cmd_done = !start_pend && bcnt_reg == 4'h7
                    && (!i2c_mode || lst_reg == L_WCMD); // [R1]
  assign link_kind = decode_cmd(byte_in);
  assign fresh = !lview_reg.busy && lview_reg.tag != served_tag_reg;
  assign rd_load = i2c_mode && !start_pend && lst_reg == L_ACK_A && rw_reg;

  // Answer chosen when the command byte completes
  always_comb begin
    resp_now = '0;
    if (link_kind == CMD_READ_RESULT && fresh) begin
      resp_now = lview_reg.result; // [R2] [R7] [R8]
    end else if (link_kind == CMD_READ_MEM) begin
      resp_now = {lview_reg.mem[(MEM_WORDS-1-int'(byte_in[FIELD_MSB:FIELD_LSB]))*WORD_W +: WORD_W],
                  8'h00}; // [R3] [R12]
    end
  end

  // Command handoff, served tag and held two-wire answer
  always_ff @(posedge i_sclk) begin
    if (lk_rst) begin
      cmd_byte_reg <= 8'h00;
      cmd_tgl_reg <= 1'b0;
      served_tag_reg <= '0;
      resp_reg <= '0;
      resp_is_mem_reg <= 1'b0;
    end else if (cmd_done) begin
      cmd_byte_reg <= byte_in;
      cmd_tgl_reg <= ~cmd_tgl_reg;
      resp_reg <= resp_now; // [R19]
      resp_is_mem_reg <= link_kind == CMD_READ_MEM;
      if (link_kind == CMD_READ_RESULT) begin
        served_tag_reg <= lview_reg.tag; // Repeat read gives zero [R8]
      end else if (link_kind == CMD_RESET) begin
        served_tag_reg <= '0;
      end
    end else if (rd_load && !resp_is_mem_reg) begin
      resp_reg <= '0; // [R8]
    end
  end

  // ----------------------------------------------------------------
  // Link domain: bit engine for both protocols
  // ----------------------------------------------------------------
  // Chip select high ends a four-wire frame at once
  assign frame_clr = !i_protocol_select_pin && i_select_bar_pin; // [R11]

  always_ff @(posedge i_sclk or posedge frame_clr) begin
    if (frame_clr) begin
      lst_reg <= L_IDLE;
      bcnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= '0;
      rw_reg <= 1'b0;
    end else if (lk_rst) begin
      lst_reg <= L_IDLE;
      bcnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= '0;
      rw_reg <= 1'b0;
    end else if (!i2c_mode) begin
      // Four-wire: 8 command bits in, then answer shifted out [R24]
      if (bcnt_reg != 4'h8) begin
        rx_reg <= byte_in;
        bcnt_reg <= bcnt_reg + 4'h1;
      end else begin
        tx_reg <= tx_reg << 1;
      end
      if (bcnt_reg == 4'h7) begin
        tx_reg <= resp_now; // [R2] [R12]
      end
    end else if (start_pend) begin
      lst_reg <= L_ADDR; // [R15]
      rx_reg <= {7'h00, i_serial_in_pin};
      bcnt_reg <= 4'h1;
    end else begin
      unique case (lst_reg)
        L_IDLE: begin
          bcnt_reg <= 4'h0;
        end
        L_ADDR: begin
          rx_reg <= byte_in;
          bcnt_reg <= bcnt_reg + 4'h1;
          if (bcnt_reg == 4'h7) begin
            bcnt_reg <= 4'h0;
            rw_reg <= i_serial_in_pin;
            lst_reg <= rx_reg[6:0] == {I2C_ADDR_HI, addr_c} ? L_ACK_A : L_IDLE; // [R16]
          end
        end
        L_ACK_A: begin
          bcnt_reg <= 4'h0;
          if (rw_reg) begin
            lst_reg <= L_RDATA;
            tx_reg <= resp_reg; // [R19] [R21]
          end else begin
            lst_reg <= L_WCMD;
          end
        end
        L_WCMD: begin
          rx_reg <= byte_in;
          bcnt_reg <= bcnt_reg + 4'h1;
          if (bcnt_reg == 4'h7) begin
            bcnt_reg <= 4'h0;
            lst_reg <= L_ACK_C;
          end
        end
        L_ACK_C: begin
          lst_reg <= L_WCMD;
        end
        L_RDATA: begin
          tx_reg <= tx_reg << 1;
          bcnt_reg <= bcnt_reg + 4'h1;
          if (bcnt_reg == 4'h7) begin
            bcnt_reg <= 4'h0;
            lst_reg <= L_RACK; // [R22]
          end
        end
        L_RACK: begin
          lst_reg <= i_serial_in_pin ? L_IDLE : L_RDATA; // [R22]
        end
        default: begin
          lst_reg <= L_IDLE;
        end
      endcase
    end
  end

  // Start seen marker follows the start toggle
  always_ff @(posedge i_sclk) begin
    if (lk_rst) begin
      start_seen_reg <= 1'b0;
    end else begin
      start_seen_reg <= start_tgl_reg;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: pin drivers, changed on the falling clock edge
  // ----------------------------------------------------------------
  assign o_serial_data_out = 1'b0; // Open drain: only ever pulls low

  always_ff @(negedge i_sclk) begin
    if (lk_rst) begin
      o_serial_out_pin <= 1'b0;
      o_serial_data_oe <= 1'b0;
    end else begin
      o_serial_out_pin <= tx_reg[RESULT_W-1]; // [R7] [R24]
      o_serial_data_oe <= i2c_mode && (lst_reg == L_ACK_A || lst_reg == L_ACK_C
                          || (lst_reg == L_RDATA && !tx_reg[RESULT_W-1])); // [R18] [R22]
    end
  end

endmodule

// *** tb/baro_serial_port_sva.sv ***
// Port assertions of the sensor serial command port
`timescale 1ns/1ps
module baro_serial_port_sva
  import baro_cmd_pkg::*;
#(
  parameter int unsigned CONV_BASE_CYCLES = CONV_BASE_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_sclk,
  input wire logic i_protocol_select_pin,
  input wire logic o_serial_data_out,
  input wire logic o_serial_data_oe,
  input wire conv_req_t o_conv,
  input wire logic o_busy
);
  // ------
  // Busy length counter
  // ------
  int unsigned busy_cnt;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || !o_busy) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end

  // ------
  // Assertions and covers
  // ------
  a_reset_idle: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    $fell(i_srst) |-> !o_busy && o_conv == 5'h0) else $error("request left after reset");
  a_start_pulse: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_conv.start |=> !o_conv.start) else $error("start longer than one cycle");
  a_start_busy: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_conv.start |-> ##[0:1] o_busy) else $error("start without busy");
  a_ratio_legal: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_conv.start |-> o_conv.ratio <= RATIO_MAX) else $error("ratio out of range");
  a_busy_length: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    $fell(o_busy) |-> busy_cnt == (CONV_BASE_CYCLES << o_conv.ratio)) else $error("wrong busy length");
  a_conv_held: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_busy && $past(o_busy) |-> $stable(o_conv.ratio) && $stable(o_conv.is_temperature))
    else $error("request changed while busy");
  a_spi_no_drive: assert property (@(posedge i_sclk) disable iff (i_srst)
    !i_protocol_select_pin |-> !o_serial_data_oe) else $error("data line driven in four-wire mode");
  a_drive_low_only: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_serial_data_out == 1'b0) else $error("data line value not low");
  c_pressure: cover property (@(posedge i_ref_clk) o_conv.start && !o_conv.is_temperature);
  c_temperature: cover property (@(posedge i_ref_clk) o_conv.start && o_conv.is_temperature);
  c_long: cover property (@(posedge i_ref_clk) $fell(o_busy) && o_conv.ratio == 3'h4);
endmodule

bind baro_serial_port baro_serial_port_sva #(.CONV_BASE_CYCLES(CONV_BASE_CYCLES)) chk (
  .i_ref_clk(i_ref_clk),
  .i_srst(i_srst),
  .i_sclk(i_sclk),
  .i_protocol_select_pin(i_protocol_select_pin),
  .o_serial_data_out(o_serial_data_out),
  .o_serial_data_oe(o_serial_data_oe),
  .o_conv(o_conv),
  .o_busy(o_busy)
);

// *** tb/host_spi_model.sv ***
// Host microcontroller model: four-wire link master in clock mode 0 or 3
`timescale 1ns/1ps
module host_spi_model (
  input wire logic i_serial_out_pin,
  output logic o_sclk,
  output logic o_serial_in_pin,
  output logic o_select_bar_pin
);
  initial begin
    o_sclk = 1'b0;
    o_serial_in_pin = 1'b0;
    o_select_bar_pin = 1'b1;
  end

  // Deselected clocks, around reset and while waiting for idle
  task automatic pulses(input int n);
    repeat (n) begin
      #3 o_sclk = 1'b1;
      #3 o_sclk = 1'b0;
    end
  endtask

  // One frame: byte msb first, answer sampled on rising edges
  task automatic xfer(input logic [7:0] cmd, input int nrd, input logic mode3, output logic [23:0] rd);
    rd = 24'h0;
    o_sclk = mode3;
    #3 o_select_bar_pin = 1'b0;
    for (int i = 0; i < 8 + nrd; i++) begin
      o_sclk = 1'b0;
      o_serial_in_pin = (i < 8) ? cmd[7 - i] : ~o_serial_in_pin;
      #3 o_sclk = 1'b1;
      if (i >= 8) rd = {rd[22:0], i_serial_out_pin};
      #3;
    end
    if (!mode3) o_sclk = 1'b0;
    #3 o_select_bar_pin = 1'b1;
    o_serial_in_pin = ~o_serial_in_pin;
  endtask
endmodule

// *** tb/test_baro_serial_port.sv ***
// Self-checking bench of the sensor serial command port on the four-wire link
`timescale 1ns/1ps
module test_baro_serial_port;
  import baro_cmd_pkg::*;
  localparam int unsigned BASE = 4;
  localparam logic [MEM_W-1:0] IMG = 128'h4d1c_92e7_0b5a_f316_68c4_a0d9_3e71_b82f;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic proto = 1'b0;
  logic sclk, serial_in_pin, sel_n, serial_out_pin, dout, doe, busy;
  raw_sample_t raw = '0;
  conv_req_t conv, last;
  int errors = 0;
  int samples_checked = 0;
  int starts = 0;

  baro_serial_port #(.CONV_BASE_CYCLES(BASE), .FACTORY_IMAGE(IMG)) dut (
    .i_ref_clk(ref_clk), .i_srst(srst), .i_sclk(sclk), .i_serial_in_pin(serial_in_pin),
    .i_protocol_select_pin(proto), .i_select_bar_pin(sel_n), .i_raw(raw), .o_serial_out_pin(serial_out_pin),
    .o_serial_data_out(dout), .o_serial_data_oe(doe), .o_conv(conv), .o_busy(busy));
  host_spi_model host (.i_serial_out_pin(serial_out_pin), .o_sclk(sclk), .o_serial_in_pin(serial_in_pin), .o_select_bar_pin(sel_n));

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  // Capture each request pulse away from the edge
  always @(negedge ref_clk) begin
    if (conv.start === 1'b1) begin
      starts++;
      last = conv;
    end
  end

  // ------
  // Helpers
  // ------
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  function automatic logic [MEM_W-1:0] image_with_code(input logic [MEM_W-1:0] m);
    logic [3:0] r;
    logic fb;
    m[3:0] = 4'h0;
    r = 4'h0;
    for (int i = MEM_W - 1; i >= 0; i--) begin
      fb = r[3] ^ m[i];
      r = {r[2:0], 1'b0} ^ (fb ? 4'h3 : 4'h0);
    end
    m[3:0] = r;
    return m;
  endfunction

  task automatic send(input logic [7:0] c, input logic m3);
    logic [23:0] rd;
    host.xfer(c, 0, m3, rd);
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  task automatic wait_idle;
    int n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    // Idle clocks let the finished state cross into the link
    host.pulses(20);
    repeat (8) @(posedge ref_clk);
    #1;
    check("busy", 24'h0, 24'(busy));
  endtask

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ------
  // Scenarios
  // ------
  task automatic t_memory;
    logic [MEM_W-1:0] exp;
    logic [23:0] rd;
    exp = image_with_code(IMG);
    for (int i = 0; i < MEM_WORDS; i++) begin
      host.xfer(8'ha0 + 8'(2 * i), 16, i[0], rd);
      check("memory word", 24'(exp[127 - 16 * i -: 16]), rd);
    end
    $display("memory test done");
  endtask

  task automatic t_misuse;
    logic [23:0] rd;
    int s = starts;
    host.xfer(8'h00, 24, 1'b0, rd);
    check("result without conversion", 24'h0, rd);
    send(8'h4a, 1'b0);
    send(8'hff, 1'b1);
    check("requests", 24'(s), 24'(starts));
    check("busy", 24'h0, 24'(busy));
    $display("misuse test done");
  endtask

  task automatic t_convert;
    logic [7:0] c;
    logic [23:0] rd;
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      #1;
      c = 8'h40 + 8'(16 * (i / 5)) + 8'(2 * (i % 5));
      raw.pressure = 24'ha1b2c3 + 24'(i);
      raw.temperature = 24'h3c2d1e - 24'(i);
      send(c, i[0]);
      check("request ratio", 24'(i % 5), 24'(last.ratio));
      check("request type", 24'(i / 5), 24'(last.is_temperature));
      wait_idle();
      host.xfer(8'h00, 24, !i[0], rd);
      check("result", (i < 5) ? raw.pressure : raw.temperature, rd);
      host.xfer(8'h00, 24, i[0], rd);
      check("repeated result", 24'h0, rd);
    end
    $display("conversion test done");
  endtask

  task automatic t_read_busy;
    logic [23:0] rd;
    send(8'h58, 1'b1);
    host.xfer(8'h00, 24, 1'b0, rd);
    check("result while busy", 24'h0, rd);
    check("busy after early read", 24'h1, 24'(busy));
    wait_idle();
    host.xfer(8'h00, 24, 1'b1, rd);
    check("spoiled result", raw.temperature ^ CORRUPT_MASK, rd);
    $display("early read test done");
  endtask

  task automatic t_reset_cmd;
    logic [23:0] rd;
    send(8'h40, 1'b0);
    wait_idle();
    send(8'h1e, 1'b1);
    host.xfer(8'h00, 24, 1'b0, rd);
    check("result after reset command", 24'h0, rd);
    $display("reset command test done");
  endtask

  initial begin
    host.pulses(4);
    @(posedge ref_clk);
    #1 srst = 1'b0;
    host.pulses(12);
    repeat (8) @(posedge ref_clk);
    t_memory();
    t_misuse();
    t_convert();
    t_read_busy();
    t_reset_cmd();
    t_memory();
    stop_test();
  end

  initial begin
    #400000;
    errors++;
    $display("unexpected watchdog: expected finish, seen hang");
    stop_test();
  end
endmodule
